// >>> src/dcc_pkg.sv
// Package for the device configuration control register block.
// Assumes a single AXI4-Lite slave port with 32-bit data on one clock.
package dcc_pkg;
	localparam int DCC_ADDR_W = 8;
	// Register byte offsets on the AXI4-Lite port.
	localparam logic [7:0] DCC_CFG_OFFS = 8'h00;
	localparam logic [7:0] DCC_UNLOCK_OFFS = 8'h04;
	localparam logic [7:0] DCC_STATUS_OFFS = 8'h08;
	// Field positions in the configuration control register.
	localparam int DCC_PIN_LOCK_BIT = 13;
	localparam int DCC_MOD_LOCK_BIT = 12;
	localparam int DCC_DBG_EN_BIT = 3;
	localparam int DCC_DOUT_SEL_BIT = 0;
	// Mask of implemented bits; all others read zero and ignore writes.
	localparam logic [31:0] DCC_CFG_MASK = 32'h0000_3009;
	localparam logic [31:0] DCC_CFG_RESET = 32'h0000_0001;
	// Two-key unlock sequence written back to back to the unlock register.
	localparam logic [31:0] DCC_KEY1 = 32'haa99_6655;
	localparam logic [31:0] DCC_KEY2 = 32'h5566_99aa;
	localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
	localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		DCC_LOCKED,
		DCC_KEY1_SEEN,
		DCC_UNLOCKED
	} dcc_unlock_t;

	typedef struct packed {
		logic pin_select_lock;
		logic module_disable_lock;
		logic debug_port_enable;
		logic two_wire_data_out_select;
	} dcc_ctrl_t;
endpackage

// >>> src/dcc_regs.sv
// Device configuration control register with lock bits and debug port bits.
// Assumes an AXI4-Lite master and downstream remap and module-disable register banks.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dcc_regs
	import dcc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [DCC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [DCC_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic remap_wr_req,
	output logic remap_wr_en,
	input wire logic mdis_wr_req,
	output logic mdis_wr_en,
	output dcc_ctrl_t ctrl
);
	logic aw_hold_ff, w_hold_ff;
	logic [DCC_ADDR_W-1:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic bvalid_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [31:0] cfg_ff, nxt_cfg;
	dcc_unlock_t ulk_ff, nxt_ulk;
	logic rej_ff, nxt_rej;

	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire aw_have = aw_hold_ff || aw_take;
	wire w_have = w_hold_ff || w_take;
	wire [DCC_ADDR_W-1:0] wr_addr = aw_hold_ff ? aw_addr_ff : s_axi_awaddr;
	wire [31:0] wr_data = w_hold_ff ? w_data_ff : s_axi_wdata;
	wire [3:0] wr_strb = w_hold_ff ? w_strb_ff : s_axi_wstrb;
	wire wr_fire = aw_have && w_have && !bvalid_ff;
	wire wr_cfg = wr_fire && (wr_addr == DCC_CFG_OFFS);
	wire wr_ulk = wr_fire && (wr_addr == DCC_UNLOCK_OFFS);
	wire wr_sts = wr_fire && (wr_addr == DCC_STATUS_OFFS);
	wire wr_bad = wr_fire && !wr_cfg && !wr_ulk && !wr_sts;
	wire [31:0] cfg_req = strb_merge(cfg_ff, wr_data, wr_strb) & DCC_CFG_MASK;
	wire lock_mask_ok = (ulk_ff == DCC_UNLOCKED);
	wire [31:0] lock_bits = (32'h1 << DCC_PIN_LOCK_BIT) | (32'h1 << DCC_MOD_LOCK_BIT);
	wire lock_change = |((cfg_req ^ cfg_ff) & lock_bits);
	wire rd_fire = s_axi_arvalid && s_axi_arready;
	wire [31:0] status_word = {29'h0, rej_ff, (ulk_ff == DCC_UNLOCKED), (ulk_ff == DCC_KEY1_SEEN)};

	assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready = !w_hold_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	// Locked lock bits keep their old value; other fields still take the write.
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_rej = rej_ff;
		if (wr_cfg) begin
			nxt_cfg = cfg_req;
			if (lock_change && !lock_mask_ok) begin
				nxt_cfg = (cfg_req & ~lock_bits) | (cfg_ff & lock_bits);
				nxt_rej = 1'b1;
			end
		end
		if (wr_sts && wr_strb[0] && wr_data[2]) begin
			nxt_rej = 1'b0;
		end
	end

	// Any unlock-register write other than the key pair relocks; other writes only cancel a half-done key pair, reads never relock.
	always_comb begin
		nxt_ulk = ulk_ff;
		if (wr_ulk) begin
			if (wr_data == DCC_KEY1) begin
				nxt_ulk = DCC_KEY1_SEEN;
			end else if (wr_data == DCC_KEY2 && ulk_ff == DCC_KEY1_SEEN) begin
				nxt_ulk = DCC_UNLOCKED;
			end else begin
				nxt_ulk = DCC_LOCKED;
			end
		end else if (wr_fire && ulk_ff == DCC_KEY1_SEEN) begin
			nxt_ulk = DCC_LOCKED;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff <= DCC_CFG_RESET;
			ulk_ff <= DCC_LOCKED;
			rej_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			ulk_ff <= nxt_ulk;
			rej_ff <= nxt_rej;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_data_ff <= 32'h0;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= DCC_RESP_OKAY;
		end else begin
			aw_hold_ff <= aw_have && !wr_fire;
			w_hold_ff <= w_have && !wr_fire;
			if (aw_take) begin
				aw_addr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_bad ? DCC_RESP_SLVERR : DCC_RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= DCC_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= DCC_RESP_OKAY;
			unique case (s_axi_araddr)
				DCC_CFG_OFFS: rdata_ff <= cfg_ff & DCC_CFG_MASK;
				DCC_UNLOCK_OFFS: rdata_ff <= 32'h0;
				DCC_STATUS_OFFS: rdata_ff <= status_word;
				default: begin
					rdata_ff <= 32'h0;
					rresp_ff <= DCC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign remap_wr_en = remap_wr_req && !cfg_ff[DCC_PIN_LOCK_BIT];
	assign mdis_wr_en = mdis_wr_req && !cfg_ff[DCC_MOD_LOCK_BIT];
	assign ctrl.pin_select_lock = cfg_ff[DCC_PIN_LOCK_BIT];
	assign ctrl.module_disable_lock = cfg_ff[DCC_MOD_LOCK_BIT];
	assign ctrl.debug_port_enable = cfg_ff[DCC_DBG_EN_BIT];
	assign ctrl.two_wire_data_out_select = cfg_ff[DCC_DOUT_SEL_BIT];

	a_remap_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		remap_wr_en |-> (remap_wr_req && !ctrl.pin_select_lock))
		else $error("remap write passed while locked");
	a_mdis_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(mdis_wr_req && !ctrl.module_disable_lock) |-> mdis_wr_en)
		else $error("module disable write wrongly blocked");
	a_mdis_block: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.module_disable_lock |-> !mdis_wr_en)
		else $error("module disable write passed while locked");
	a_dbg_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_cfg && wr_strb[0]) |=> (ctrl.debug_port_enable == $past(wr_data[DCC_DBG_EN_BIT])))
		else $error("debug enable did not follow write");
	a_dout_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_cfg && wr_strb[0]) |=> (ctrl.two_wire_data_out_select == $past(wr_data[0])))
		else $error("data-out select did not follow write");
	a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(rd_fire && s_axi_araddr == DCC_CFG_OFFS) |=> ((s_axi_rdata & ~DCC_CFG_MASK) == 32'h0))
		else $error("unimplemented bits read nonzero");
	a_lock_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(ulk_ff != DCC_UNLOCKED) |=> ($stable(ctrl.pin_select_lock) && $stable(ctrl.module_disable_lock)))
		else $error("lock bit changed without unlock");
	a_unlock_seq: assert property (@(posedge aclk) disable iff (!aresetn)
		(ulk_ff != DCC_UNLOCKED) ##1 (ulk_ff == DCC_UNLOCKED) |-> $past(wr_ulk && wr_data == DCC_KEY2))
		else $error("unlocked without second key");
	a_bresp_once: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_axi_bvalid)
		else $error("write response missing");

	// Gate checks in both directions, so a stuck-open or stuck-closed gate is caught.
	a_remap_open: assert property (@(posedge aclk) disable iff (!aresetn)
		(remap_wr_req && !ctrl.pin_select_lock) |-> remap_wr_en)
		else $error("remap write wrongly blocked");
	a_remap_block: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.pin_select_lock |-> !remap_wr_en)
		else $error("remap write passed while pin lock set");
	a_lock_stay: assert property (@(posedge aclk) disable iff (!aresetn)
		!wr_cfg |=> ($stable(ctrl.pin_select_lock) && $stable(ctrl.module_disable_lock)))
		else $error("lock bit moved without a write");
	a_reset_cfg: assert property (@(posedge aclk)
		!aresetn |=> (cfg_ff == DCC_CFG_RESET))
		else $error("configuration reset value wrong");

	// Stored and returned words never carry unimplemented bits.
	a_unimpl_store: assert property (@(posedge aclk) disable iff (!aresetn)
		(cfg_ff & ~DCC_CFG_MASK) == 32'h0)
		else $error("unimplemented bit stored");
	a_read_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
		(rd_fire && s_axi_araddr == DCC_CFG_OFFS) |=> (s_axi_rdata == $past(cfg_ff)))
		else $error("configuration read data wrong");
	a_bad_noeffect: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_bad |=> $stable(cfg_ff))
		else $error("unmapped write changed configuration");
	a_bad_wresp: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_bad |=> (s_axi_bresp == DCC_RESP_SLVERR))
		else $error("unmapped write not refused");

	// Unlocked writes land whole; locked writes still move the debug bits.
	a_lock_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_cfg && lock_mask_ok) |=> (cfg_ff == $past(cfg_req)))
		else $error("unlocked write did not land");
	a_dbg_locked: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_cfg && !lock_mask_ok) |=> ((cfg_ff & ~lock_bits) == ($past(cfg_req) & ~lock_bits)))
		else $error("debug bits blocked by lock state");
	a_rej_set: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_cfg && lock_change && !lock_mask_ok) |=> rej_ff)
		else $error("refused lock change not flagged");
	a_rej_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		(rej_ff && !(wr_sts && wr_strb[0] && wr_data[2])) |=> rej_ff)
		else $error("rejection flag lost");
	a_rej_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_sts && wr_strb[0] && wr_data[2]) |=> !rej_ff)
		else $error("rejection flag not cleared");

	// Key sequencing.
	a_key_first: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_ulk && wr_data == DCC_KEY1) |=> (ulk_ff == DCC_KEY1_SEEN))
		else $error("first key not seen");
	a_key_relock: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_ulk && wr_data != DCC_KEY1 && wr_data != DCC_KEY2) |=> (ulk_ff == DCC_LOCKED))
		else $error("stray unlock write did not relock");

	// Bus handshake holds.
	a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
		else $error("write response dropped early");
	a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
		else $error("read response dropped early");
	a_rvalid_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_fire |=> s_axi_rvalid)
		else $error("read response missing");
	a_ready_busy: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
		else $error("write accepted while response pending");
	a_ar_busy: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while response pending");

	c_unlock: cover property (@(posedge aclk) disable iff (!aresetn) ulk_ff == DCC_UNLOCKED);
	c_locked_rej: cover property (@(posedge aclk) disable iff (!aresetn) $rose(rej_ff));
	c_pin_lock: cover property (@(posedge aclk) disable iff (!aresetn) $rose(ctrl.pin_select_lock));
	c_remap_block: cover property (@(posedge aclk) disable iff (!aresetn) remap_wr_req && !remap_wr_en);
endmodule

// >>> tb/device_config_control_reg_tb.sv
// Self-checking bench for the configuration control register block.
// Assumes the block answers over AXI4-Lite on one 100 MHz clock.
`timescale 1ns/1ps
module device_config_control_reg_tb;
	import dcc_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d, e, v;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rq = 1'b0, mq = 1'b0, ren, men;
	logic [1:0] bresp, rresp, r;
	dcc_ctrl_t ctrl;
	int n_mismatch = 0, samples_checked = 0;
	always #5 aclk = ~aclk;
	dcc_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .remap_wr_req(rq), .remap_wr_en(ren), .mdis_wr_req(mq), .mdis_wr_en(men),
		.ctrl(ctrl));
	task test_done;
		$display("compares %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	// Both channels are offered together; each is dropped once taken, bready stays up until bvalid.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge aclk);
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 50) begin n_mismatch++; test_done(); end
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata; r = rresp;
		rready <= 1'b0;
		if (n == 50) begin n_mismatch++; test_done(); end
	endtask
	// Reads the register back, then checks the control outputs and both write gates with random requests.
	task automatic check_all;
		logic [1:0] q;
		rd(DCC_CFG_OFFS);
		chk(d, e);
		q = 2'($urandom_range(3));
		rq <= q[1]; mq <= q[0];
		@(posedge aclk);
		@(posedge aclk);
		chk({28'h0, ctrl}, {28'h0, e[13], e[12], e[3], e[0]});
		chk({30'h0, ren, men}, {30'h0, q[1] & !e[13], q[0] & !e[12]});
	endtask
	initial begin
		void'($urandom(32'h8c6198fc));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		e = 32'h1;
		check_all();
		// Without the key pair only the debug bits may move; the first value tries every bit.
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 32'hffff_ffff : $urandom;
			e = (e & 32'h3000) | (v & 32'h9);
			wr(DCC_CFG_OFFS, v);
			chk({30'h0, r}, {30'h0, DCC_RESP_OKAY});
			check_all();
		end
		wr(DCC_UNLOCK_OFFS, DCC_KEY1);
		wr(DCC_UNLOCK_OFFS, DCC_KEY2);
		wr(DCC_CFG_OFFS, 32'hffff_fff6);
		e = 32'h3000;
		check_all();
		// A non-key write relocks, so the clear attempt below must be refused.
		wr(DCC_UNLOCK_OFFS, 32'h0);
		wr(DCC_CFG_OFFS, 32'h9);
		e = 32'h3009;
		check_all();
		rd(DCC_STATUS_OFFS);
		chk(d & 32'h7, 32'h4);
		wr(DCC_UNLOCK_OFFS, DCC_KEY1);
		wr(DCC_UNLOCK_OFFS, DCC_KEY2);
		wr(DCC_CFG_OFFS, 32'h0);
		e = 32'h0;
		check_all();
		wr(8'h10, 32'hffff_ffff);
		chk({30'h0, r}, {30'h0, DCC_RESP_SLVERR});
		rd(8'h10);
		chk({d[29:0], r}, {30'h0, DCC_RESP_SLVERR});
		chk(d, 32'h0);
		check_all();
		test_done();
	end
endmodule
